// *** verilog/ifm_defines.svh ***
`ifndef IFM_DEFINES_SVH
`define IFM_DEFINES_SVH

// ****************************************
// Mode and revision codes
// ****************************************
`define IFM_PRIV_KERNEL  2'h0
`define IFM_UNIT_ZERO    2'h0
`define IFM_REV_ONE      3'h1
`define IFM_REV_TWO      3'h2
`define IFM_REV_WRAP_ALL 3'h6
`define IFM_ARCH_TYPE_A  2'h1
`define IFM_ARCH_TYPE_B  2'h2

// ****************************************
// Widths and reset values
// ****************************************
`define IFM_GPR_WIDTH    32
`define IFM_NBITS_WIDTH  6
`define IFM_RST_BIT      1'b0
`define IFM_RST_WORD     32'h0000_0000

`endif

// *** verilog/ifm_pkg.sv ***
package ifm_pkg;

    typedef struct packed {
        logic [1:0] privilegeModeField;
        logic       debugModeFlag;
        logic       exceptionLevelFlag;
        logic       errorLevelFlag;
        logic [3:0] coprocUsableBits;
    } ifm_status_t;

    typedef struct packed {
        logic       coprocTwoPresentBit;
        logic       debugPortPresentBit;
        logic       floatUnitPresentBit;
        logic [1:0] archTypeField;
        logic [2:0] archRevision;
    } ifm_config_t;

    typedef struct packed {
        logic singleBit;
        logic doubleBit;
        logic wordBit;
        logic longBit;
        logic pairedSingleBit;
    } ifm_fimpl_t;

    typedef enum logic [2:0] {
        FMT_ANY    = 3'h0,
        FMT_SINGLE = 3'h1,
        FMT_DOUBLE = 3'h2,
        FMT_WORD   = 3'h3,
        FMT_LONG   = 3'h4,
        FMT_PAIRED = 3'h5
    } ifm_fmt_t;

    typedef enum logic [1:0] {
        ACC_FETCH  = 2'h0,
        ACC_DATA   = 2'h1,
        ACC_BRANCH = 2'h3,
        ACC_PCREL  = 2'h2
    } ifm_acc_t;

    typedef struct packed {
        logic        valid;
        logic        excReq;
        logic [4:0]  excType;
        logic [31:0] excArg;
        logic        debugBreak;
        logic        nullify;
        logic        branchLikely;
    } ifm_instr_t;

    typedef struct packed {
        logic        commit;
        logic        abort;
        logic        excTaken;
        logic [4:0]  excType;
        logic [31:0] excArg;
        logic        enterDebug;
        logic        debugModeExc;
        logic        killDelaySlot;
    } ifm_outcome_t;

endpackage : ifm_pkg

// *** verilog/ifm_feature_checks.sv ***
`timescale 1ns/100ps
`include "ifm_defines.svh"

module ifm_feature_checks
#(
    parameter int GPRW = `IFM_GPR_WIDTH
)
(
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    input  wire ifm_pkg::ifm_status_t         statusIn,
    input  wire ifm_pkg::ifm_config_t         configIn,
    input  wire ifm_pkg::ifm_fimpl_t          fimplIn,
    input  wire logic [1:0]                   cpUnit,
    input  wire ifm_pkg::ifm_fmt_t            fmtSel,
    input  wire logic [GPRW-1:0]              extVal,
    input  wire logic [`IFM_NBITS_WIDTH-1:0]  extBits,
    input  wire logic [31:0]                  eaIn,
    input  wire ifm_pkg::ifm_acc_t            eaKind,
    input  wire logic [31:0]                  polyX,
    input  wire logic [31:0]                  polyY,
    input  wire ifm_pkg::ifm_instr_t          instrIn,
    output logic                              cpEnabled_r,
    output logic                              cp2Present_r,
    output logic                              dbgPortPresent_r,
    output logic                              floatPresent_r,
    output logic [GPRW-1:0]                   sextOut_r,
    output logic [31:0]                       eaOut_r,
    output logic                              wrapApplied_r,
    output logic [31:0]                       polyOut_r,
    output ifm_pkg::ifm_outcome_t             outcome_r
);
    import ifm_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta_r;
    logic rstSync_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= `IFM_RST_BIT;
            rstSync_n <= `IFM_RST_BIT;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    // ****************************************
    // Decoding functions
    // ****************************************
    function automatic logic archTypeWide(input ifm_config_t c);
        archTypeWide = (c.archTypeField == `IFM_ARCH_TYPE_A) ||
                       (c.archTypeField == `IFM_ARCH_TYPE_B);
    endfunction : archTypeWide

    function automatic logic floatQuery(input ifm_config_t c,
                                        input ifm_fimpl_t f,
                                        input ifm_fmt_t fmt);
        logic revOne;
        logic revTwo;
        revOne = (c.archRevision == `IFM_REV_ONE);
        revTwo = (c.archRevision >= `IFM_REV_TWO);
        if (!c.floatUnitPresentBit) begin
            floatQuery = 1'b0;
        end else begin
            case (fmt)
                FMT_ANY:    floatQuery = 1'b1;
                FMT_SINGLE: floatQuery = f.singleBit;
                FMT_DOUBLE: floatQuery = f.doubleBit;
                FMT_WORD: begin
                    floatQuery = (revOne && f.singleBit) ||
                                 (revTwo && f.wordBit);
                end
                FMT_LONG: begin
                    floatQuery = (revOne && archTypeWide(c)) ||
                                 (revTwo && f.longBit);
                end
                FMT_PAIRED: begin
                    floatQuery = f.pairedSingleBit &&
                                 ((revOne && archTypeWide(c)) ||
                                  revTwo);
                end
                default:    floatQuery = 1'b0;
            endcase
        end
    endfunction : floatQuery

    function automatic logic unitUsable(input ifm_status_t s,
                                        input logic [1:0] unit);
        case (unit)
            `IFM_UNIT_ZERO: begin
                unitUsable = (s.privilegeModeField == `IFM_PRIV_KERNEL) ||
                             s.debugModeFlag || s.exceptionLevelFlag ||
                             s.errorLevelFlag;
            end
            default: unitUsable = s.coprocUsableBits[unit];
        endcase
    endfunction : unitUsable

    function automatic logic [GPRW-1:0] signExtend(
        input logic [GPRW-1:0]             val,
        input logic [`IFM_NBITS_WIDTH-1:0] nbits);
        logic [GPRW-1:0] res;
        logic            top;
        res = '0;
        top = 1'b0;
        if (nbits != '0 && int'(nbits) <= GPRW) begin
            top = val[int'(nbits) - 1];
        end
        for (int i = 0; i < GPRW; i++) begin
            res[i] = (i < int'(nbits)) ? val[i] : top;
        end
        signExtend = res;
    endfunction : signExtend

    function automatic logic [31:0] polyMultiply(input logic [31:0] x,
                                                 input logic [31:0] y);
        logic [31:0] acc;
        acc = '0;
        for (int i = 0; i < 32; i++) begin
            if (x[i]) begin
                acc = acc ^ (y << i);
            end
        end
        polyMultiply = acc;
    endfunction : polyMultiply

    // ****************************************
    // Presence and usability
    // ****************************************
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cpEnabled_r <= `IFM_RST_BIT;
        end else begin
            cpEnabled_r <= unitUsable(statusIn, cpUnit);
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cp2Present_r     <= `IFM_RST_BIT;
            dbgPortPresent_r <= `IFM_RST_BIT;
        end else begin
            cp2Present_r     <= configIn.coprocTwoPresentBit;
            dbgPortPresent_r <= configIn.debugPortPresentBit;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            floatPresent_r <= `IFM_RST_BIT;
        end else begin
            floatPresent_r <= floatQuery(configIn, fimplIn, fmtSel);
        end
    end

    // ****************************************
    // Data path helpers
    // ****************************************
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sextOut_r <= '0;
        end else begin
            sextOut_r <= signExtend(extVal, extBits);
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            eaOut_r       <= `IFM_RST_WORD;
            wrapApplied_r <= `IFM_RST_BIT;
        end else begin
            eaOut_r <= eaIn;
            case (eaKind)
                ACC_FETCH, ACC_DATA: wrapApplied_r <= 1'b1;
                ACC_BRANCH, ACC_PCREL: begin
                    wrapApplied_r <= (configIn.archRevision >=
                                      `IFM_REV_WRAP_ALL);
                end
                default: wrapApplied_r <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            polyOut_r <= `IFM_RST_WORD;
        end else begin
            polyOut_r <= polyMultiply(polyX, polyY);
        end
    end

    // ****************************************
    // Abort, debug entry and nullify
    // ****************************************
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            outcome_r <= '0;
        end else begin
            outcome_r <= '0;
            if (instrIn.valid) begin
                if (instrIn.nullify) begin
                    outcome_r.abort         <= 1'b1;
                    outcome_r.killDelaySlot <= instrIn.branchLikely;
                end else if (instrIn.debugBreak) begin
                    outcome_r.abort <= 1'b1;
                    if (statusIn.debugModeFlag) begin
                        outcome_r.debugModeExc <= 1'b1;
                    end else begin
                        outcome_r.enterDebug <= 1'b1;
                    end
                end else if (instrIn.excReq) begin
                    outcome_r.abort    <= 1'b1;
                    outcome_r.excTaken <= 1'b1;
                    outcome_r.excType  <= instrIn.excType;
                    outcome_r.excArg   <= instrIn.excArg;
                end else begin
                    outcome_r.commit <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_unit_zero_kernel: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (cpUnit == 2'h0 && statusIn.privilegeModeField != 2'h0 &&
         !statusIn.debugModeFlag && !statusIn.exceptionLevelFlag &&
         !statusIn.errorLevelFlag) |=> !cpEnabled_r)
        else $error("unit zero enabled outside privileged state");

    chk_unit_usable_bit: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (cpUnit != 2'h0) |=>
            cpEnabled_r == $past(statusIn.coprocUsableBits[cpUnit]))
        else $error("unit usability differs from its usable bit");

    chk_float_absent: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        !configIn.floatUnitPresentBit |=> !floatPresent_r)
        else $error("float format reported without float unit");

    chk_word_rev_one: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (configIn.floatUnitPresentBit && fmtSel == FMT_WORD &&
         configIn.archRevision == 3'h1) |=>
            floatPresent_r == $past(fimplIn.singleBit))
        else $error("word format at revision one ignores single bit");

    chk_paired_needs_bit: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (fmtSel == FMT_PAIRED && !fimplIn.pairedSingleBit) |=>
            !floatPresent_r)
        else $error("paired format reported without its bit");

    chk_sext_top_bit: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (extBits == 6'h10) |=>
            sextOut_r[GPRW-1] == $past(extVal[15]) &&
            sextOut_r[15:0] == $past(extVal[15:0]))
        else $error("sign extension of sixteen bits wrong");

    chk_wrap_release: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (eaKind == ACC_BRANCH && configIn.archRevision < 3'h6) |=>
            !wrapApplied_r ##1 1'b1)
        else $error("branch wrapping applied before release six");

    chk_nullify_silent: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (instrIn.valid && instrIn.nullify) |=>
            outcome_r.abort && !outcome_r.excTaken &&
            !outcome_r.enterDebug && !outcome_r.debugModeExc &&
            !outcome_r.commit)
        else $error("nullified instruction raised or committed");

    chk_debug_path: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (instrIn.valid && !instrIn.nullify && instrIn.debugBreak) |=>
            outcome_r.debugModeExc == $past(statusIn.debugModeFlag) &&
            outcome_r.enterDebug != outcome_r.debugModeExc)
        else $error("debug exception took the wrong path");

    chk_exc_abort: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        outcome_r.excTaken |-> outcome_r.abort && !outcome_r.commit &&
            outcome_r.excArg == $past(instrIn.excArg))
        else $error("exception did not abort with its argument");

    chk_poly_one: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (polyX == 32'h0000_0001) |=> polyOut_r == $past(polyY))
        else $error("multiply by one does not return operand");

    chk_cp2_follows: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        rstSync_n |=> cp2Present_r == $past(configIn.coprocTwoPresentBit))
        else $error("coprocessor two presence differs from its bit");

    chk_ea_unchanged: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        rstSync_n |=> eaOut_r == $past(eaIn))
        else $error("effective address altered by wrapping");

    chk_fetch_wrapped: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (rstSync_n && (eaKind == ACC_FETCH || eaKind == ACC_DATA)) |=>
            wrapApplied_r)
        else $error("fetch or data access not wrapped");

    chk_nullify_kill: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (instrIn.valid && instrIn.nullify) |=>
            outcome_r.killDelaySlot == $past(instrIn.branchLikely))
        else $error("delay slot kill differs from branch likely");

    chk_debug_enter: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (instrIn.valid && !instrIn.nullify && instrIn.debugBreak &&
         !statusIn.debugModeFlag) |=>
            outcome_r.abort && outcome_r.enterDebug)
        else $error("breakpoint outside debug mode did not enter it");

    chk_generic_query: assert property (
        @(posedge core_clk) disable iff (!rstSync_n)
        (configIn.floatUnitPresentBit && fmtSel == FMT_ANY) |=>
            floatPresent_r)
        else $error("generic float query false with float unit");

endmodule : ifm_feature_checks

// *** tb/isa_feature_mode_checks_bench.sv ***
`timescale 1ns/100ps

module isa_feature_mode_checks_bench;
    import ifm_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic         core_clk;
    logic         reset_n;
    ifm_status_t  st;
    ifm_config_t  cf;
    ifm_fimpl_t   fi;
    logic [1:0]   cpUnit;
    ifm_fmt_t     fmtSel;
    logic [31:0]  extVal;
    logic [5:0]   extBits;
    logic [31:0]  eaIn;
    ifm_acc_t     eaKind;
    logic [31:0]  polyX;
    logic [31:0]  polyY;
    ifm_instr_t   ins;
    logic         cpEn;
    logic         cp2;
    logic         dbgP;
    logic         flt;
    logic [31:0]  sext;
    logic [31:0]  eaOut;
    logic         wrap;
    logic [31:0]  poly;
    ifm_outcome_t oc;
    int           badCount = 0;
    int           nChecks = 0;
    logic [31:0]  e;
    logic [31:0]  m;
    logic [31:0]  v;
    logic [5:0]   e6;
    logic [31:0]  px [5] = '{32'h0, 32'h1, 32'hffff_ffff, 32'h8000_0000,
                            32'ha5a5_0f0f};
    logic [31:0]  py [5] = '{32'h1234_5678, 32'hcafe_f00d, 32'hffff_ffff,
                            32'h0000_0003, 32'h1234_5678};

    ifm_feature_checks uut (
        .core_clk         (core_clk),
        .reset_n          (reset_n),
        .statusIn         (st),
        .configIn         (cf),
        .fimplIn          (fi),
        .cpUnit           (cpUnit),
        .fmtSel           (fmtSel),
        .extVal           (extVal),
        .extBits          (extBits),
        .eaIn             (eaIn),
        .eaKind           (eaKind),
        .polyX            (polyX),
        .polyY            (polyY),
        .instrIn          (ins),
        .cpEnabled_r      (cpEn),
        .cp2Present_r     (cp2),
        .dbgPortPresent_r (dbgP),
        .floatPresent_r   (flt),
        .sextOut_r        (sext),
        .eaOut_r          (eaOut),
        .wrapApplied_r    (wrap),
        .polyOut_r        (poly),
        .outcome_r        (oc)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        nChecks++;
        if (got !== ex) begin
            $display("mismatch %s expected %h seen %h", nm, ex, got);
            badCount++;
        end
    endtask : chk

    task automatic chkb(input string nm, input logic ex, input logic got);
        chk(nm, {31'h0, ex}, {31'h0, got});
    endtask : chkb

    function automatic logic fexp(input logic fp, input logic [2:0] rev,
                                  input logic [1:0] at, input ifm_fimpl_t f,
                                  input logic [2:0] fmt);
        logic typ;
        typ = (rev == 3'h1) && (at == 2'h1 || at == 2'h2);
        if (!fp)
            return 1'b0;
        case (fmt)
            3'h0: return 1'b1;
            3'h1: return f.singleBit;
            3'h2: return f.doubleBit;
            3'h3: return (rev == 3'h1 && f.singleBit) ||
                         (rev >= 3'h2 && f.wordBit);
            3'h4: return typ || (rev >= 3'h2 && f.longBit);
            3'h5: return f.pairedSingleBit && (typ || rev >= 3'h2);
            default: return 1'b0;
        endcase
    endfunction : fexp

    function automatic logic [31:0] pmul(input logic [31:0] x,
                                         input logic [31:0] y);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            if (x[i])
                r = r ^ (y << i);
        end
        return r;
    endfunction : pmul

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrapUp

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #500_000;
        badCount++;
        wrapUp();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        st = '0;
        cf = '0;
        fi = '0;
        cpUnit = 2'h0;
        fmtSel = FMT_ANY;
        extVal = 32'h0;
        extBits = 6'h0;
        eaIn = 32'h0;
        eaKind = ACC_FETCH;
        polyX = 32'h0;
        polyY = 32'h0;
        ins = '0;
        repeat (3) @(posedge core_clk);
        #1;
        chk("idleOut", 32'h0, sext | eaOut | poly);
        chkb("idleFlag", 1'b0, cpEn | cp2 | dbgP | flt | wrap | oc.commit);
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Usability and presence, new state every query
        for (int i = 0; i < 128; i++) begin
            @(posedge core_clk);
            st <= '{i[1:0], i[2], i[3], i[4], i[4:1]};
            cf <= '{i[0], i[1], 1'b0, 2'h0, 3'h1};
            cpUnit <= i[6:5];
            @(posedge core_clk);
            #1;
            e[0] = (i[6:5] == 0) ? (i[1:0] == 0 || i[2] || i[3] || i[4])
                                 : i[1 + i[6:5]];
            chkb("cpEnabled", e[0], cpEn);
            chkb("cp2Present", i[0], cp2);
            chkb("dbgPortPresent", i[1], dbgP);
        end
        // Every format, revision, type and implementation bit set
        for (int j = 0; j < 16384; j++) begin
            @(posedge core_clk);
            fi <= ifm_fimpl_t'(j[7:3]);
            fmtSel <= ifm_fmt_t'(j[2:0]);
            cf <= '{1'b0, 1'b0, j[13], j[9:8], j[12:10]};
            @(posedge core_clk);
            #1;
            e[0] = fexp(j[13], j[12:10], j[9:8], ifm_fimpl_t'(j[7:3]),
                        j[2:0]);
            chkb("floatPresent", e[0], flt);
        end
        // Sign extension over every source width
        for (int n = 0; n < 128; n++) begin
            v = n[0] ? 32'haaaa_5555 : 32'h5555_aaaa;
            @(posedge core_clk);
            extVal <= v;
            extBits <= n[6:1];
            @(posedge core_clk);
            #1;
            m = (n[6:1] >= 32) ? 32'hffff_ffff : (32'h1 << n[6:1]) - 32'h1;
            e = v & m;
            if (n[6:1] >= 1 && n[6:1] <= 32 && v[n[6:1] - 1])
                e = e | ~m;
            chk("sextOut", e, sext);
        end
        // Address pass-through and wrapping scope
        for (int a = 0; a < 32; a++) begin
            v = 32'h9abc_de00 ^ {a[7:0], a[7:0], a[7:0], a[7:0]};
            @(posedge core_clk);
            eaIn <= v;
            eaKind <= ifm_acc_t'(a[1:0]);
            cf <= '{1'b0, 1'b0, 1'b0, 2'h0, a[4:2]};
            @(posedge core_clk);
            #1;
            chk("eaOut", v, eaOut);
            chkb("wrapApplied", a[1:0] < 2 || a[4:2] >= 6, wrap);
        end
        // Carry-less multiply
        for (int p = 0; p < 5; p++) begin
            @(posedge core_clk);
            polyX <= px[p];
            polyY <= py[p];
            @(posedge core_clk);
            #1;
            chk("polyOut", pmul(px[p], py[p]), poly);
        end
        // Instruction outcome for every flag combination
        for (int k = 0; k < 32; k++) begin
            v = 32'h1234_5600 ^ {24'h0, k[7:0]};
            @(posedge core_clk);
            st <= '{2'h3, k[4], 1'b0, 1'b0, 4'h0};
            ins <= '{1'b1, k[2], k[4:0], v, k[1], k[0], k[3]};
            @(posedge core_clk);
            ins.valid <= 1'b0;
            #1;
            if (k[0])
                e6 = {5'h08, k[3]};
            else if (k[1])
                e6 = {3'h2, !k[4], k[4], 1'b0};
            else if (k[2])
                e6 = 6'h18;
            else
                e6 = 6'h20;
            chk("outcome", {26'h0, e6}, {26'h0, oc.commit, oc.abort,
                oc.excTaken, oc.enterDebug, oc.debugModeExc,
                oc.killDelaySlot});
            if (e6 == 6'h18) begin
                chk("excType", {27'h0, k[4:0]}, {27'h0, oc.excType});
                chk("excArg", v, oc.excArg);
            end
            @(posedge core_clk);
            #1;
            chkb("pulseEnd", 1'b0, oc.commit | oc.abort | oc.excTaken);
        end
        wrapUp();
    end

endmodule : isa_feature_mode_checks_bench
